// ==== rtl/mdcem_defs.svh ====
`ifndef MDCEM_DEFS_SVH
`define MDCEM_DEFS_SVH

// ****************************************
// Register map (word indices and address pages)
// ****************************************
`define MDCEM_CFG_IDX_BASE 3'h0
`define MDCEM_GLB_IDX_BASE 3'h4
`define MDCEM_REG_PAGE 27'h0000000
`define MDCEM_STA_PAGE 20'h00001

// ****************************************
// Driver configuration word fields
// ****************************************
`define MDCEM_CFG_CONT 0
`define MDCEM_CFG_RETRY 1
`define MDCEM_CFG_MSG 2
`define MDCEM_CFG_ETH 3
`define MDCEM_CFG_CNT_LSB 16
`define MDCEM_CFG_RESET 32'h01000000

// ****************************************
// Error word fields, shared by global and station words
// ****************************************
`define MDCEM_W_POLL 0
`define MDCEM_W_INIT 1
`define MDCEM_W_ERR 4
`define MDCEM_W_RLOG 6
`define MDCEM_W_WLOG 7

// ****************************************
// Stored station nibble: {wlog, rlog, err, poll}
// ****************************************
`define MDCEM_S_POLL 0
`define MDCEM_S_ERR 1
`define MDCEM_S_RLOG 2
`define MDCEM_S_WLOG 3
`define MDCEM_S_POWERUP 4'h1

`endif

// ==== rtl/mdcem_pkg.sv ====
package mdcem_pkg;

  typedef enum logic [1:0] {
    MDCEM_IDLE,
    MDCEM_BUS_RD,
    MDCEM_BUS_WR,
    MDCEM_EV_WR
  } mdcem_state_e;

  typedef enum logic [1:0] {
    MDCEM_PICK,
    MDCEM_READ,
    MDCEM_CHECK,
    MDCEM_OFFER
  } mdcem_sched_e;

endpackage

// ==== rtl/mdcem_poll_sched.sv ====
module mdcem_poll_sched
  import mdcem_pkg::*;
#(
  parameter int DRIVERS = 4,
  parameter int SW = 8,
  parameter int DW = 2
) (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Async reset, active low
  input wire logic [DRIVERS*(SW+1)-1:0] cnt_flat, // Station count per driver
  input wire logic [DRIVERS-1:0] hold, // Driver may not be polled
  input wire logic [DRIVERS-1:0] retry_act, // Driver is retrying one station
  input wire logic [DRIVERS*SW-1:0] retry_sta_flat, // Station under retry
  output logic [DW+SW-1:0] b_addr, // Table read address
  input wire logic b_poll, // Poll enable bit read back
  output logic poll_valid, // Poll request offered
  input wire logic poll_ready, // Link has taken the poll
  output logic [DW-1:0] poll_drv, // Driver of the poll
  output logic [SW-1:0] poll_sta, // Station of the poll
  output logic poll_retry // Poll is a reconnection attempt
);

  mdcem_sched_e state_reg;
  logic [DW-1:0] ptr_drv_reg;
  logic [SW-1:0] ptr_sta_reg;

  function automatic logic [SW:0] cnt_of(input logic [DRIVERS*(SW+1)-1:0] f,
                                         input logic [DW-1:0] d);
    cnt_of = f[d*(SW+1) +: (SW+1)];
  endfunction

  // Last station of a driver, or a retry, moves on to the next driver
  function automatic logic wrap(input logic [SW-1:0] s, input logic [SW:0] c,
                                input logic r);
    wrap = r || ({1'b0, s} + 1'b1 >= c);
  endfunction

  assign b_addr = {poll_drv, poll_sta};
  assign poll_valid = (state_reg == MDCEM_OFFER);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= MDCEM_PICK;
      ptr_drv_reg <= '0;
      ptr_sta_reg <= '0;
      poll_drv <= '0;
      poll_sta <= '0;
      poll_retry <= 1'b0;
    end
    else
    begin
      case (state_reg)
        MDCEM_PICK:
        begin
          if (hold[ptr_drv_reg] || cnt_of(cnt_flat, ptr_drv_reg) == '0)
          begin
            ptr_drv_reg <= ptr_drv_reg + 1'b1;
            ptr_sta_reg <= '0;
          end
          else
          begin
            poll_drv <= ptr_drv_reg;
            // Only the station under retry is polled on its driver
            poll_sta <= retry_act[ptr_drv_reg] ?
                        retry_sta_flat[ptr_drv_reg*SW +: SW] : ptr_sta_reg; // RQ3
            poll_retry <= retry_act[ptr_drv_reg]; // RQ2
            state_reg <= MDCEM_READ;
          end
        end
        MDCEM_READ:
        begin
          state_reg <= MDCEM_CHECK;
        end
        MDCEM_CHECK:
        begin
          if (b_poll && !hold[poll_drv]) // RQ13
          begin
            state_reg <= MDCEM_OFFER;
          end
          else
          begin
            state_reg <= MDCEM_PICK;
            if (wrap(ptr_sta_reg, cnt_of(cnt_flat, poll_drv), poll_retry))
            begin
              ptr_drv_reg <= ptr_drv_reg + 1'b1;
              ptr_sta_reg <= '0;
            end
            else
            begin
              ptr_sta_reg <= ptr_sta_reg + 1'b1;
            end
          end
        end
        MDCEM_OFFER:
        begin
          if (poll_ready)
          begin
            state_reg <= MDCEM_PICK;
            if (wrap(ptr_sta_reg, cnt_of(cnt_flat, poll_drv), poll_retry))
            begin
              ptr_drv_reg <= ptr_drv_reg + 1'b1;
              ptr_sta_reg <= '0;
            end
            else
            begin
              ptr_sta_reg <= ptr_sta_reg + 1'b1;
            end
          end
        end
        default:
        begin
          state_reg <= MDCEM_PICK;
        end
      endcase
    end
  end

endmodule // mdcem_poll_sched

// ==== rtl/mdcem_station_ram.sv ====
module mdcem_station_ram #(
  parameter int AW = 10,
  parameter int DW = 4
) (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Async reset, active low
  input wire logic [AW-1:0] a_addr, // Port A address
  input wire logic a_we, // Port A write enable
  input wire logic [DW-1:0] a_wdata, // Port A write data
  output logic [DW-1:0] a_rdata, // Port A registered read data
  input wire logic [AW-1:0] b_addr, // Port B address, read only
  output logic [DW-1:0] b_rdata // Port B registered read data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // No reset on the array: the top sweeps it after reset
  always_ff @(posedge hclk)
  begin
    if (a_we)
    begin
      mem[a_addr] <= a_wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_rdata <= '0;
      b_rdata <= '0;
    end
    else
    begin
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
    end
  end

endmodule // mdcem_station_ram

// ==== rtl/mdcem_top.sv ====
// Contract
// RQ1 - Config halts operation or continues on error
// RQ2 - Auto retry keeps reconnecting errored station
// RQ3 - Retry suspends other stations on driver
// RQ4 - Manual retry via init or poll bit
// RQ5 - Station area at most 256 words
// RQ6 - Init bit clears all, reads zero after
// RQ7 - Init without auto retry re-enables all stations
// RQ8 - Global error bit follows live station errors
// RQ9 - Global error bit zero without auto retry
// RQ10 - Disabled stations excluded from global error bit
// RQ11 - Global read log sticky until init
// RQ12 - Global write log sticky until init
// RQ13 - Station bit 0 gates polling
// RQ14 - Poll enable starts at one
// RQ15 - Auto retry forces poll; else error clears
// RQ16 - Station error bit follows live error
// RQ17 - Station read log sticky until init
// RQ18 - Station write log sticky until init
// RQ19 - Station words count from base, configured count
// RQ20 - Settings held per driver, four drivers
// RQ21 - Acknowledge offered only when continuing on error
// RQ22 - Station identified by slave number or ID
// RQ23 - Reserved bits read zero, writes ignored
`include "mdcem_defs.svh"

module mdcem_top
  import mdcem_pkg::*;
#(
  parameter int DRIVERS = 4,
  parameter int STATIONS = 256
) (
  input wire logic hclk, // Clock, 200 MHz
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic [31:0] hrdata, // Read data
  output logic hresp, // Always OKAY
  input wire logic ev_valid, // Poll outcome offered
  output logic ev_ready, // Poll outcome taken
  input wire logic [$clog2(DRIVERS)-1:0] ev_drv, // Driver of the outcome
  input wire logic [$clog2(STATIONS)-1:0] ev_sta, // Station of the outcome
  input wire logic ev_rd_err, // Read error at station
  input wire logic ev_wr_err, // Write error at station
  output logic poll_valid, // Poll request offered
  input wire logic poll_ready, // Poll request taken
  output logic [$clog2(DRIVERS)-1:0] poll_drv, // Driver to poll
  output logic [$clog2(STATIONS)-1:0] poll_sta, // Station to poll
  output logic poll_retry, // Poll is a reconnection attempt
  output logic [DRIVERS-1:0] id_is_eth, // Station field is a device ID
  output logic [DRIVERS-1:0] halt, // Driver stopped by an error
  output logic [DRIVERS-1:0] msg_show, // Error message shown
  output logic [DRIVERS-1:0] msg_ack // Message carries acknowledge
);

  localparam int SW = $clog2(STATIONS);
  localparam int DW = $clog2(DRIVERS);
  localparam int AW = SW + DW;
  localparam int CW = SW + 1;

  // ****************************************
  // State
  // ****************************************
  mdcem_state_e state_reg;
  logic [DRIVERS-1:0][31:0] cfg_reg;
  logic [DRIVERS-1:0] rlog_reg;
  logic [DRIVERS-1:0] wlog_reg;
  logic [DRIVERS-1:0][CW-1:0] err_cnt_reg;
  logic [DRIVERS-1:0][CW-1:0] raw_cnt_reg;
  logic [DRIVERS-1:0] retry_act_reg;
  logic [DRIVERS-1:0][SW-1:0] retry_sta_reg;
  logic sweep_busy_reg;
  logic [DRIVERS-1:0] sweep_mask_reg;
  logic [AW-1:0] sweep_addr_reg;
  logic req_pend_reg;
  logic req_wr_reg;
  logic [31:0] req_addr_reg;
  logic [31:0] hrdata_reg;
  logic [AW-1:0] op_addr_reg;
  logic op_bit_reg;
  logic op_rd_reg;
  logic op_wr_reg;

  logic [AW-1:0] a_addr;
  logic a_we;
  logic [3:0] a_wdata;
  logic [3:0] a_rdata;
  logic [AW-1:0] b_addr;
  logic [3:0] b_rdata;
  logic take;
  logic done;
  logic sta_hit;
  logic reg_hit;
  logic [2:0] reg_idx;
  logic [DW-1:0] req_drv;
  logic [SW-1:0] req_sta;
  logic sta_in_range;
  logic [DRIVERS-1:0] init_req;
  logic [DW-1:0] op_drv;
  logic [SW-1:0] op_sta;
  logic op_err;
  logic [3:0] st_next;
  logic [DRIVERS*CW-1:0] cnt_flat;
  logic [DRIVERS*SW-1:0] retry_flat;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [CW-1:0] cnt_adj(input logic [CW-1:0] c, input logic was,
                                            input logic now);
    if (now && !was)
      cnt_adj = c + 1'b1;
    else if (was && !now)
      cnt_adj = c - 1'b1;
    else
      cnt_adj = c;
  endfunction

  // Stored nibble to the 32-bit station word; unused bits stay zero
  function automatic logic [31:0] sta_view(input logic [3:0] s);
    sta_view = '0; // RQ23
    sta_view[`MDCEM_W_POLL] = s[`MDCEM_S_POLL];
    sta_view[`MDCEM_W_ERR] = s[`MDCEM_S_ERR]; // RQ16
    sta_view[`MDCEM_W_RLOG] = s[`MDCEM_S_RLOG];
    sta_view[`MDCEM_W_WLOG] = s[`MDCEM_S_WLOG];
  endfunction

  function automatic logic [CW-1:0] cfg_cnt(input logic [31:0] c);
    cfg_cnt = c[`MDCEM_CFG_CNT_LSB +: CW];
  endfunction

  // ****************************************
  // Bus address phase
  // ****************************************
  assign take = hsel && hready && htrans[1];
  assign hreadyout = !req_pend_reg;
  assign hrdata = hrdata_reg;
  assign hresp = 1'b0;
  assign sta_hit = (req_addr_reg[31:12] == `MDCEM_STA_PAGE);
  assign reg_hit = (req_addr_reg[31:5] == `MDCEM_REG_PAGE);
  assign reg_idx = req_addr_reg[4:2];
  assign req_sta = req_addr_reg[SW+1:2];
  assign req_drv = req_addr_reg[AW+1:SW+2];
  // Words past the configured count are unmapped
  assign sta_in_range = ({1'b0, req_sta} < cfg_cnt(cfg_reg[req_drv])); // RQ19 RQ5

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req_pend_reg <= 1'b0;
      req_wr_reg <= 1'b0;
      req_addr_reg <= '0;
    end
    else if (take)
    begin
      req_pend_reg <= 1'b1;
      req_wr_reg <= hwrite;
      req_addr_reg <= haddr;
    end
    else if (done)
    begin
      req_pend_reg <= 1'b0;
    end
  end

  // ****************************************
  // Access sequencer
  // ****************************************
  assign done = (state_reg == MDCEM_BUS_RD) || (state_reg == MDCEM_BUS_WR) ||
                (state_reg == MDCEM_IDLE && req_pend_reg &&
                 !(sta_hit && sta_in_range));
  assign ev_ready = (state_reg == MDCEM_IDLE) && !req_pend_reg && !sweep_busy_reg;
  assign op_drv = op_addr_reg[AW-1:SW];
  assign op_sta = op_addr_reg[SW-1:0];
  assign op_err = op_rd_reg || op_wr_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= MDCEM_IDLE;
      op_addr_reg <= '0;
      op_bit_reg <= 1'b0;
      op_rd_reg <= 1'b0;
      op_wr_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        MDCEM_IDLE:
        begin
          if (req_pend_reg && sta_hit && sta_in_range && !sweep_busy_reg)
          begin
            op_addr_reg <= {req_drv, req_sta};
            op_bit_reg <= hwdata[`MDCEM_W_POLL];
            state_reg <= req_wr_reg ? MDCEM_BUS_WR : MDCEM_BUS_RD;
          end
          else if (ev_valid && ev_ready)
          begin
            op_addr_reg <= {ev_drv, ev_sta};
            op_rd_reg <= ev_rd_err;
            op_wr_reg <= ev_wr_err;
            state_reg <= MDCEM_EV_WR;
          end
        end
        MDCEM_BUS_RD,
        MDCEM_BUS_WR,
        MDCEM_EV_WR:
        begin
          state_reg <= MDCEM_IDLE;
        end
        default:
        begin
          state_reg <= MDCEM_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Station table port A
  // ****************************************
  always_comb
  begin
    st_next = a_rdata;
    if (state_reg == MDCEM_EV_WR)
    begin
      if (op_err)
      begin
        st_next[`MDCEM_S_ERR] = 1'b1; // RQ16
        st_next[`MDCEM_S_RLOG] = a_rdata[`MDCEM_S_RLOG] | op_rd_reg; // RQ17
        st_next[`MDCEM_S_WLOG] = a_rdata[`MDCEM_S_WLOG] | op_wr_reg; // RQ18
        st_next[`MDCEM_S_POLL] = cfg_reg[op_drv][`MDCEM_CFG_RETRY]; // RQ15
      end
      else
      begin
        st_next[`MDCEM_S_ERR] = 1'b0; // RQ16
        st_next[`MDCEM_S_POLL] = a_rdata[`MDCEM_S_POLL] |
                                 cfg_reg[op_drv][`MDCEM_CFG_RETRY]; // RQ15
      end
    end
    else
    begin
      // Only the poll bit is writable; auto retry pins it high
      st_next[`MDCEM_S_POLL] = op_bit_reg | cfg_reg[op_drv][`MDCEM_CFG_RETRY]; // RQ15 RQ13
    end
  end

  always_comb
  begin
    if (sweep_busy_reg)
    begin
      a_addr = sweep_addr_reg;
      a_we = sweep_mask_reg[sweep_addr_reg[AW-1:SW]];
      a_wdata = `MDCEM_S_POWERUP; // RQ6 RQ7 RQ14
    end
    else if (state_reg == MDCEM_IDLE)
    begin
      a_addr = req_pend_reg ? {req_drv, req_sta} : {ev_drv, ev_sta};
      a_we = 1'b0;
      a_wdata = st_next;
    end
    else
    begin
      a_addr = op_addr_reg;
      a_we = (state_reg == MDCEM_BUS_WR) || (state_reg == MDCEM_EV_WR);
      a_wdata = st_next;
    end
  end

  // ****************************************
  // Initialise sweep
  // ****************************************
  always_comb
  begin
    init_req = '0;
    for (int d = 0; d < DRIVERS; d++)
    begin
      init_req[d] = (state_reg == MDCEM_IDLE) && req_pend_reg && req_wr_reg && reg_hit &&
                    reg_idx == `MDCEM_GLB_IDX_BASE + 3'(d) && hwdata[`MDCEM_W_INIT]; // RQ4
    end
  end

  // Power-up runs the sweep too: the table itself has no reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sweep_busy_reg <= 1'b1;
      sweep_mask_reg <= '1;
      sweep_addr_reg <= '0;
    end
    else if (init_req != '0)
    begin
      sweep_busy_reg <= 1'b1;
      sweep_mask_reg <= (sweep_busy_reg ? sweep_mask_reg : '0) | init_req; // RQ6
      sweep_addr_reg <= '0;
    end
    else if (sweep_busy_reg)
    begin
      sweep_addr_reg <= sweep_addr_reg + 1'b1;
      if (sweep_addr_reg == '1)
      begin
        sweep_busy_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Registers and per-driver status
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_reg <= {DRIVERS{`MDCEM_CFG_RESET}};
    end
    else
    begin
      for (int d = 0; d < DRIVERS; d++)
      begin
        if (state_reg == MDCEM_IDLE && req_pend_reg && req_wr_reg && reg_hit &&
            reg_idx == `MDCEM_CFG_IDX_BASE + 3'(d)) // RQ20
        begin
          cfg_reg[d] <= hwdata & {7'h00, {CW{1'b1}}, 12'h000, 4'hF};
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rlog_reg <= '0;
      wlog_reg <= '0;
      err_cnt_reg <= '0;
      raw_cnt_reg <= '0;
    end
    else
    begin
      for (int d = 0; d < DRIVERS; d++)
      begin
        if (init_req[d])
        begin
          rlog_reg[d] <= 1'b0; // RQ11
          wlog_reg[d] <= 1'b0; // RQ12
          err_cnt_reg[d] <= '0;
          raw_cnt_reg[d] <= '0;
        end
        else if (a_we && !sweep_busy_reg && op_drv == DW'(d))
        begin
          rlog_reg[d] <= rlog_reg[d] | (op_rd_reg && state_reg == MDCEM_EV_WR); // RQ11
          wlog_reg[d] <= wlog_reg[d] | (op_wr_reg && state_reg == MDCEM_EV_WR); // RQ12
          err_cnt_reg[d] <= cnt_adj(err_cnt_reg[d],
                                    a_rdata[`MDCEM_S_ERR] & a_rdata[`MDCEM_S_POLL],
                                    st_next[`MDCEM_S_ERR] & st_next[`MDCEM_S_POLL]); // RQ10
          raw_cnt_reg[d] <= cnt_adj(raw_cnt_reg[d], a_rdata[`MDCEM_S_ERR],
                                    st_next[`MDCEM_S_ERR]);
        end
      end
    end
  end

  // ****************************************
  // Retry tracking
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      retry_act_reg <= '0;
      retry_sta_reg <= '0;
    end
    else
    begin
      for (int d = 0; d < DRIVERS; d++)
      begin
        if (init_req[d])
        begin
          retry_act_reg[d] <= 1'b0;
        end
        else if (op_drv == DW'(d) && !sweep_busy_reg)
        begin
          if (state_reg == MDCEM_BUS_WR && op_bit_reg && !retry_act_reg[d]) // RQ4
          begin
            retry_act_reg[d] <= 1'b1;
            retry_sta_reg[d] <= op_sta;
          end
          else if (state_reg == MDCEM_EV_WR)
          begin
            if (op_err && cfg_reg[d][`MDCEM_CFG_RETRY] && !retry_act_reg[d]) // RQ2
            begin
              retry_act_reg[d] <= 1'b1;
              retry_sta_reg[d] <= op_sta;
            end
            // A manual attempt that fails, or recovery of the station under retry, ends the retry
            else if (retry_sta_reg[d] == op_sta &&
                     (!op_err || !cfg_reg[d][`MDCEM_CFG_RETRY]))
            begin
              retry_act_reg[d] <= 1'b0;
            end
          end
        end
      end
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_reg <= '0;
    end
    else if (state_reg == MDCEM_BUS_RD)
    begin
      hrdata_reg <= sta_view(a_rdata | 4'(cfg_reg[op_drv][`MDCEM_CFG_RETRY]));
    end
    else if (done && !req_wr_reg)
    begin
      hrdata_reg <= '0; // RQ23
      for (int d = 0; d < DRIVERS; d++)
      begin
        if (reg_hit && reg_idx == `MDCEM_CFG_IDX_BASE + 3'(d))
        begin
          hrdata_reg <= cfg_reg[d];
        end
        if (reg_hit && reg_idx == `MDCEM_GLB_IDX_BASE + 3'(d))
        begin
          hrdata_reg[`MDCEM_W_INIT] <= sweep_busy_reg & sweep_mask_reg[d]; // RQ6
          hrdata_reg[`MDCEM_W_ERR] <= cfg_reg[d][`MDCEM_CFG_RETRY] &
                                      (err_cnt_reg[d] != '0); // RQ8 RQ9
          hrdata_reg[`MDCEM_W_RLOG] <= rlog_reg[d]; // RQ11
          hrdata_reg[`MDCEM_W_WLOG] <= wlog_reg[d]; // RQ12
        end
      end
    end
  end

  // ****************************************
  // Driver outputs and poll scheduler
  // ****************************************
  always_comb
  begin
    for (int d = 0; d < DRIVERS; d++)
    begin
      id_is_eth[d] = cfg_reg[d][`MDCEM_CFG_ETH]; // RQ22
      halt[d] = !cfg_reg[d][`MDCEM_CFG_CONT] && raw_cnt_reg[d] != '0; // RQ1
      msg_show[d] = raw_cnt_reg[d] != '0 &&
                    (!cfg_reg[d][`MDCEM_CFG_CONT] || cfg_reg[d][`MDCEM_CFG_MSG]);
      msg_ack[d] = msg_show[d] && cfg_reg[d][`MDCEM_CFG_CONT]; // RQ21
      cnt_flat[d*CW +: CW] = cfg_cnt(cfg_reg[d]);
      retry_flat[d*SW +: SW] = retry_sta_reg[d];
    end
  end

  mdcem_station_ram #(
    .AW(AW),
    .DW(4)
  ) u_ram (
    .hclk(hclk),
    .hresetn(hresetn),
    .a_addr(a_addr),
    .a_we(a_we),
    .a_wdata(a_wdata),
    .a_rdata(a_rdata),
    .b_addr(b_addr),
    .b_rdata(b_rdata)
  );

  mdcem_poll_sched #(
    .DRIVERS(DRIVERS),
    .SW(SW),
    .DW(DW)
  ) u_sched (
    .hclk(hclk),
    .hresetn(hresetn),
    .cnt_flat(cnt_flat),
    .hold(halt | {DRIVERS{sweep_busy_reg}}), // RQ1
    .retry_act(retry_act_reg),
    .retry_sta_flat(retry_flat),
    .b_addr(b_addr),
    .b_poll(b_rdata[`MDCEM_S_POLL] | cfg_reg[poll_drv][`MDCEM_CFG_RETRY]),
    .poll_valid(poll_valid),
    .poll_ready(poll_ready),
    .poll_drv(poll_drv),
    .poll_sta(poll_sta),
    .poll_retry(poll_retry)
  );

endmodule // mdcem_top

// ==== verif/mdcem_chk_monitor.sv ====
module mdcem_chk_monitor #(
  parameter int DRIVERS = 4,
  parameter int STATIONS = 256
) (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic hsel, // Select
  input wire logic hready, // Bus ready
  input wire logic [1:0] htrans, // Transfer
  input wire logic hreadyout, // Slave ready
  input wire logic ev_valid, // Outcome
  input wire logic ev_ready, // Taken
  input wire logic poll_valid, // Poll
  input wire logic poll_ready, // Taken
  input wire logic [$clog2(STATIONS)-1:0] poll_sta, // Station
  input wire logic [DRIVERS-1:0] halt, // Stopped
  input wire logic [DRIVERS-1:0] msg_show, // Message
  input wire logic [DRIVERS-1:0] msg_ack // Ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence bus_take;
    hsel && hready && htrans[1];
  endsequence
  sequence poll_take;
    poll_valid && poll_ready;
  endsequence
  chk_bus_wait: assert property (bus_take |=> !hreadyout)
    else $error("bus answer early");
  chk_ev_block: assert property (!hreadyout |-> !ev_ready)
    else $error("outcome during bus");
  chk_ev_gap: assert property (ev_valid && ev_ready |=> !ev_ready)
    else $error("outcome gap");
  chk_poll_hold: assert property (poll_valid && !poll_ready |=> poll_valid && $stable(poll_sta))
    else $error("poll dropped");
  chk_poll_gap: assert property (poll_take |=> !poll_valid [*3])
    else $error("poll too soon");
  chk_halt_msg: assert property ((halt & ~msg_show) == '0)
    else $error("halt without message");
  chk_ack_msg: assert property ((msg_ack & ~msg_show) == '0)
    else $error("ack without message");
  chk_ack_halt: assert property ((msg_ack & halt) == '0)
    else $error("ack while halted");
endmodule // mdcem_chk_monitor

bind mdcem_top mdcem_chk_monitor #(.DRIVERS(DRIVERS), .STATIONS(STATIONS)) mdcem_chk_monitor_inst (
  .hclk, .hresetn, .hsel, .hready, .htrans, .hreadyout, .ev_valid, .ev_ready,
  .poll_valid, .poll_ready, .poll_sta, .halt, .msg_show, .msg_ack);

// ==== verif/mdcem_link_model.sv ====
module mdcem_link_model (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic poll_valid, // Poll
  output logic poll_ready, // Taken
  input wire logic [1:0] poll_drv, // Driver
  input wire logic [7:0] poll_sta, // Station
  output logic ev_valid, // Outcome
  input wire logic ev_ready, // Taken
  output logic [1:0] ev_drv, // Driver
  output logic [7:0] ev_sta, // Station
  output logic ev_rd_err, // Read fail
  output logic ev_wr_err, // Write fail
  input wire logic bad_rd, // Fail reads
  input wire logic bad_wr // Fail writes
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slow_reg;
  // Busy every other cycle, so polls must wait
  assign poll_ready = !ev_valid && slow_reg;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ev_valid <= 1'b0;
      slow_reg <= 1'b0;
    end
    else
    begin
      slow_reg <= !slow_reg;
      if (ev_valid && ev_ready)
      begin
        ev_valid <= 1'b0;
        // Released lines flip
        {ev_drv, ev_sta, ev_rd_err, ev_wr_err} <= ~{ev_drv, ev_sta, ev_rd_err, ev_wr_err};
      end
      else if (poll_valid && poll_ready)
      begin
        ev_valid <= 1'b1;
        {ev_drv, ev_sta, ev_rd_err, ev_wr_err} <= {poll_drv, poll_sta, bad_rd, bad_wr};
      end
    end
endmodule // mdcem_link_model

// ==== verif/multidrop_comm_error_monitor_bench.sv ====
module multidrop_comm_error_monitor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ev_valid, ev_ready, ev_rd_err;
  logic ev_wr_err, poll_valid, poll_ready, poll_retry, bad_rd, bad_wr;
  logic [1:0] htrans, ev_drv, poll_drv;
  logic [2:0] hsize;
  logic [7:0] ev_sta, poll_sta;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [3:0] halt, msg_show, msg_ack, id_is_eth;
  int errors, samples_checked;
  assign hready = hreadyout;
  mdcem_top mdcem_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hrdata, .hresp, .ev_valid, .ev_ready, .ev_drv, .ev_sta, .ev_rd_err,
    .ev_wr_err, .poll_valid, .poll_ready, .poll_drv, .poll_sta, .poll_retry, .id_is_eth,
    .halt, .msg_show, .msg_ack);
  mdcem_link_model mdcem_link_model_inst (.hclk, .hresetn, .poll_valid, .poll_ready, .poll_drv,
    .poll_sta, .ev_valid, .ev_ready, .ev_drv, .ev_sta, .ev_rd_err, .ev_wr_err, .bad_rd, .bad_wr);
  task summarize();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(string nm, logic [31:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdy();
    int n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      if (++n > 3000)
      begin
        errors++;
        summarize();
      end
      @(posedge hclk);
    end
  endtask
  task automatic ahb(logic w, logic [31:0] a, d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask
  task automatic wait_reg(logic [31:0] a, e);
    int n = 0;
    do
      ahb(1'b0, a, 32'h0);
    while (r !== e && ++n < 1000);
    chk($sformatf("word %h", a), e, r);
  endtask
  task t_reset();
    for (int d = 0; d < 4; d++)
    begin
      ahb(1'b0, 32'(d * 4), 32'h0);
      chk("config", 32'h01000000, r);
      ahb(1'b1, 32'(d * 4), 32'h0);
    end
    ahb(1'b1, 32'h0, 32'h00010000);
    wait_reg(32'h1000, 32'h1);
    ahb(1'b1, 32'h1000, 32'hFFFFFF3E);
    wait_reg(32'h1000, 32'h0);
    wait_reg(32'h800, 32'h0);
  endtask
  task t_retry();
    ahb(1'b1, 32'h0, 32'h0001000B);
    bad_rd <= 1'b1;
    wait_reg(32'h1000, 32'h51);
    wait_reg(32'h10, 32'h50);
    chk("halt", 32'h1, {halt, id_is_eth});
    bad_rd <= 1'b0;
    wait_reg(32'h1000, 32'h41);
    wait_reg(32'h10, 32'h40);
    ahb(1'b1, 32'h10, 32'h2);
    wait_reg(32'h1000, 32'h1);
    wait_reg(32'h10, 32'h0);
  endtask
  task t_halt();
    ahb(1'b1, 32'h0, 32'h00010004);
    bad_wr <= 1'b1;
    wait_reg(32'h1000, 32'h90);
    wait_reg(32'h10, 32'h80);
    chk("message", 32'h110, {hresp, halt, msg_show, msg_ack});
    bad_wr <= 1'b0;
    ahb(1'b1, 32'h10, 32'h2);
    wait_reg(32'h1000, 32'h1);
  endtask
  task t_manual();
    ahb(1'b1, 32'h0, 32'h00010001);
    bad_rd <= 1'b1;
    wait_reg(32'h1000, 32'h50);
    chk("halt", 32'h0, halt);
    bad_rd <= 1'b0;
    ahb(1'b1, 32'h1000, 32'h1);
    wait_reg(32'h1000, 32'h41);
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial
  begin
    {hresetn, hwrite, bad_rd, bad_wr, htrans, haddr, hwdata} = '0;
    hsel = 1'b1;
    hsize = 3'h2;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_retry();
    t_halt();
    t_manual();
    summarize();
  end
endmodule // multidrop_comm_error_monitor_bench
